// [rtl/tmc_pkg.sv]
// Purpose: Shared constants for the dual timer/counter block.
// Assumes: Special-function byte addresses, 8-bit data.
// Notes: Mode codes are the two-bit mode field values.
`default_nettype none
package tmc_pkg;
   // ----------------------------------------------------------------
   // Register byte addresses in the special-function space
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h88; // Run bits and overflow flags
   localparam logic [7:0] ADDR_TIMER_MODE_SELECT = 8'h89; // Mode, source, pin-qualify
   localparam logic [7:0] ADDR_TIMER0_COUNT_LOW = 8'h8A; // Timer 0 low byte
   localparam logic [7:0] ADDR_TIMER1_COUNT_LOW = 8'h8B; // Timer 1 low byte
   localparam logic [7:0] ADDR_TIMER0_COUNT_HIGH = 8'h8C; // Timer 0 high byte
   localparam logic [7:0] ADDR_TIMER1_COUNT_HIGH = 8'h8D; // Timer 1 high byte
   localparam logic [2:0] BIT_ADDR_LOW_BITS = 3'h0; // Address ends in 0 or 8
   // ----------------------------------------------------------------
   // Mode select field positions
   // ----------------------------------------------------------------
   localparam int MODE_T1_QUALIFY_BIT = 7; // Timer 1 pin-qualify
   localparam int MODE_T1_SOURCE_BIT = 6; // Timer 1 count source
   localparam int MODE_T1_FIELD_HI = 5; // Timer 1 mode_field_high
   localparam int MODE_T1_FIELD_LO = 4; // Timer 1 mode_field_low
   localparam int MODE_T0_QUALIFY_BIT = 3; // Timer 0 pin-qualify
   localparam int MODE_T0_SOURCE_BIT = 2; // Timer 0 count source
   localparam int MODE_T0_FIELD_HI = 1; // Timer 0 mode_field_high
   localparam int MODE_T0_FIELD_LO = 0; // Timer 0 mode_field_low
   // ----------------------------------------------------------------
   // Control register field positions
   // ----------------------------------------------------------------
   localparam int CTRL_T1_OVERFLOW_BIT = 7; // Timer 1 overflow flag
   localparam int CTRL_T1_RUN_BIT = 6; // timer1_run_bit
   localparam int CTRL_T0_OVERFLOW_BIT = 5; // Timer 0 overflow flag
   localparam int CTRL_T0_RUN_BIT = 4; // timer0_run_bit
   // ----------------------------------------------------------------
   // Mode codes, reset values, timing
   // ----------------------------------------------------------------
   localparam logic [1:0] MODE_PRESCALED = 2'h0; // 8-bit with 5-bit prescale
   localparam logic [1:0] MODE_WIDE = 2'h1; // 16-bit
   localparam logic [1:0] MODE_RELOAD = 2'h2; // 8-bit auto-reload
   localparam logic [1:0] MODE_SPLIT = 2'h3; // Split (timer 0) / stopped (timer 1)
   localparam int PRESCALE_BITS = 5; // Prescaler width in low byte
   localparam logic [7:0] RESET_BYTE = 8'h00; // Reset value of every register
   localparam int MACHINE_CYCLE_CLOCKS = 12; // Core clocks per internal count
endpackage
`default_nettype wire

// [rtl/tmc_pin_if.sv]
// Purpose: Carries one synchronised pin level and its falling edge.
// Assumes: Both sides on core_clk.
// Notes: Driven by tmc_pin_sync, read by the timer core.
`default_nettype none
interface tmc_pin_if;
   logic level; // Synchronised pin level
   logic fall; // One-cycle pulse on a high-to-low change
   modport src (output level, output fall);
   modport sink (input level, input fall);
endinterface
`default_nettype wire

// [rtl/tmc_pin_sync.sv]
// Purpose: Two-flop synchroniser with falling-edge detect for one pin.
// Assumes: Pin is asynchronous to core_clk.
// Notes: Edge is taken between the second and third flops only.
`default_nettype none
module tmc_pin_sync (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic pin_async,
   tmc_pin_if.src pin
);
   logic meta_r; // First flop, read only by the second
   logic sync_r; // Second flop
   logic prev_r; // Previous synchronised level
   logic meta_nxt;
   logic sync_nxt;
   logic prev_nxt;

   // ----------------------------------------------------------------
   // Next values
   // ----------------------------------------------------------------
   always_comb begin
      meta_nxt = pin_async;
      sync_nxt = meta_r;
      prev_nxt = sync_r;
   end

   // ----------------------------------------------------------------
   // Registers; pins idle high after reset
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         meta_r <= 1'b1;
         sync_r <= 1'b1;
         prev_r <= 1'b1;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
         prev_r <= prev_nxt;
      end
   end

   assign pin.level = sync_r;
   assign pin.fall = prev_r & ~sync_r;
endmodule
`default_nettype wire

// [rtl/tmc_timer_top.sv]
// Purpose: Two timer/counter channels behind special-function registers.
// Assumes: Core drives one-cycle read, byte-write and bit-write strobes.
// Notes: Internal count rate is one tick per machine cycle.
//
// Function
// RULE_01: Timer 1 qualify: needs pin high and run
// RULE_02: Timer 0 qualify: needs pin high and run
// RULE_03: Qualify clear: pin ignored, run bit alone
// RULE_04: Timer 1 source: machine cycles or pin falls
// RULE_05: Timer 0 source: machine cycles or pin falls
// RULE_06: Mode 00: 8-bit count, 5-bit prescaler
// RULE_07: Mode 01: full 16-bit counter
// RULE_08: Mode 10: low byte reloads from high
// RULE_09: Mode 11: timer 0 split, high uses timer 1 controls
// RULE_10: Timer 1 mode 11 holds its value
// RULE_11: Bit access only at addresses ending 0/8
// RULE_12: Indirect accesses are ignored
// RULE_13: Rollover to zero sets overflow flag; timer 1 rollover sets no flag while timer 0 is in mode 11
// RULE_14: Mode field bit positions per timer
`default_nettype none
module tmc_timer_top #(
   parameter int MACH_DIV = tmc_pkg::MACHINE_CYCLE_CLOCKS
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_indirect,
   input wire logic sfr_rd,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_bit_wr,
   input wire logic [2:0] sfr_bit_sel,
   input wire logic sfr_bit_val,
   input wire logic ext_irq_pin_zero,
   input wire logic ext_irq_pin_one,
   input wire logic timer0_count_pin,
   input wire logic timer1_count_pin,
   output logic [7:0] sfr_rdata,
   output logic timer0_overflow,
   output logic timer1_overflow
);
   // ----------------------------------------------------------------
   // Elaboration check
   // ----------------------------------------------------------------
   if (MACH_DIV < 1 || MACH_DIV > 16) begin : g_bad_div
      $error("MACH_DIV must lie in 1..16");
   end

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   tmc_pin_if irq0_p (); // ext_irq_pin_zero
   tmc_pin_if irq1_p (); // ext_irq_pin_one
   tmc_pin_if cnt0_p (); // timer0_count_pin
   tmc_pin_if cnt1_p (); // timer1_count_pin

   tmc_pin_sync u_irq0 (.core_clk(core_clk), .reset_n(reset_n), .pin_async(ext_irq_pin_zero), .pin(irq0_p));
   tmc_pin_sync u_irq1 (.core_clk(core_clk), .reset_n(reset_n), .pin_async(ext_irq_pin_one), .pin(irq1_p));
   tmc_pin_sync u_cnt0 (.core_clk(core_clk), .reset_n(reset_n), .pin_async(timer0_count_pin), .pin(cnt0_p));
   tmc_pin_sync u_cnt1 (.core_clk(core_clk), .reset_n(reset_n), .pin_async(timer1_count_pin), .pin(cnt1_p));

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [3:0] mc_cnt_r; // Machine-cycle divider
   logic [3:0] mc_cnt_nxt;
   logic mc_en; // One-cycle pulse per machine cycle
   logic [7:0] timer_control_r; // Run bits and overflow flags
   logic [7:0] timer_control_nxt;
   logic [7:0] timer_mode_select_r; // Mode select register
   logic [7:0] timer_mode_select_nxt;
   logic [7:0] timer0_count_low_r; // Timer 0 low byte
   logic [7:0] timer0_count_low_nxt;
   logic [7:0] timer0_count_high_r; // Timer 0 high byte
   logic [7:0] timer0_count_high_nxt;
   logic [7:0] timer1_count_low_r; // Timer 1 low byte
   logic [7:0] timer1_count_low_nxt;
   logic [7:0] timer1_count_high_r; // Timer 1 high byte
   logic [7:0] timer1_count_high_nxt;
   logic [7:0] rdata_r; // Registered read data
   logic [7:0] rdata_nxt;

   // Decoded controls
   logic [1:0] mode0; // Timer 0 mode field
   logic [1:0] mode1; // Timer 1 mode field
   logic run0; // Timer 0 run bit
   logic run1; // Timer 1 run bit
   logic enable0; // Timer 0 allowed to count
   logic enable1; // Timer 1 allowed to count
   logic tick0; // Timer 0 advances this cycle
   logic tick1; // Timer 1 advances this cycle
   logic tick0_high; // Split high byte advances
   logic [16:0] step0; // {carry, high, low} for timer 0
   logic [16:0] step1; // {carry, high, low} for timer 1
   logic [8:0] split_high; // Split high byte plus carry
   logic ovf0; // Timer 0 rollover event
   logic ovf1; // Timer 1 flag event
   logic direct_acc; // Access is by direct address

   // ----------------------------------------------------------------
   // One count step for a given mode: returns {carry, high, low}
   // ----------------------------------------------------------------
   function automatic logic [16:0] count_step(input logic [1:0] m, input logic [7:0] lo, input logic [7:0] hi);
      logic [13:0] s13;
      logic [16:0] s16;
      logic [8:0] s8;
      s13 = {1'b0, hi, lo[tmc_pkg::PRESCALE_BITS-1:0]} + 14'h0001;
      s16 = {1'b0, hi, lo} + 17'h00001;
      s8 = {1'b0, lo} + 9'h001;
      unique case (m)
         // Upper three low-byte bits stay put in the prescaled mode
         tmc_pkg::MODE_PRESCALED: count_step = {s13[13], s13[12:5], lo[7:5], s13[4:0]}; // RULE_06
         tmc_pkg::MODE_WIDE: count_step = s16; // RULE_07
         tmc_pkg::MODE_RELOAD: count_step = {s8[8], hi, (s8[8] ? hi : s8[7:0])}; // RULE_08
         tmc_pkg::MODE_SPLIT: count_step = {s8[8], hi, s8[7:0]}; // RULE_09
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Count qualification
   // ----------------------------------------------------------------
   always_comb begin
      mode0 = {timer_mode_select_r[tmc_pkg::MODE_T0_FIELD_HI],
               timer_mode_select_r[tmc_pkg::MODE_T0_FIELD_LO]}; // RULE_14
      mode1 = {timer_mode_select_r[tmc_pkg::MODE_T1_FIELD_HI],
               timer_mode_select_r[tmc_pkg::MODE_T1_FIELD_LO]}; // RULE_14
      run0 = timer_control_r[tmc_pkg::CTRL_T0_RUN_BIT];
      run1 = timer_control_r[tmc_pkg::CTRL_T1_RUN_BIT];
      // Qualify bit set: pin must be high too; clear: pin ignored
      enable0 = run0 & (~timer_mode_select_r[tmc_pkg::MODE_T0_QUALIFY_BIT] | irq0_p.level); // RULE_02 RULE_03
      enable1 = run1 & (~timer_mode_select_r[tmc_pkg::MODE_T1_QUALIFY_BIT] | irq1_p.level); // RULE_01 RULE_03
      // Source: internal machine cycle or synchronised pin fall
      tick0 = enable0 & (timer_mode_select_r[tmc_pkg::MODE_T0_SOURCE_BIT] ? cnt0_p.fall : mc_en); // RULE_05
      tick1 = enable1 & (timer_mode_select_r[tmc_pkg::MODE_T1_SOURCE_BIT] ? cnt1_p.fall : mc_en) &
              (mode1 != tmc_pkg::MODE_SPLIT); // RULE_04 RULE_10
      // Split high byte is a plain timer gated by timer 1 run bit only
      tick0_high = (mode0 == tmc_pkg::MODE_SPLIT) & run1 & mc_en; // RULE_09
      step0 = count_step(mode0, timer0_count_low_r, timer0_count_high_r);
      step1 = count_step(mode1, timer1_count_low_r, timer1_count_high_r);
      split_high = {1'b0, timer0_count_high_r} + 9'h001;
   end

   // ----------------------------------------------------------------
   // Register next values: counting, then software writes
   // ----------------------------------------------------------------
   always_comb begin
      mc_cnt_nxt = (mc_cnt_r == 4'(MACH_DIV - 1)) ? 4'h0 : mc_cnt_r + 4'h1;
      timer_control_nxt = timer_control_r;
      timer_mode_select_nxt = timer_mode_select_r;
      timer0_count_low_nxt = timer0_count_low_r;
      timer0_count_high_nxt = timer0_count_high_r;
      timer1_count_low_nxt = timer1_count_low_r;
      timer1_count_high_nxt = timer1_count_high_r;
      rdata_nxt = rdata_r;
      ovf0 = 1'b0;
      ovf1 = 1'b0;
      direct_acc = ~sfr_indirect; // RULE_12
      // Timer 0 advance
      if (tick0) begin
         timer0_count_low_nxt = step0[7:0];
         if (mode0 != tmc_pkg::MODE_SPLIT) begin
            timer0_count_high_nxt = step0[15:8];
         end
         ovf0 = step0[16]; // RULE_13
      end
      // Split high byte advance takes over timer 1 flag
      if (tick0_high) begin
         timer0_count_high_nxt = split_high[7:0];
         ovf1 = split_high[8]; // RULE_09 RULE_13
      end
      // Timer 1 advance; flag owned by split high byte in split mode
      if (tick1) begin
         timer1_count_low_nxt = step1[7:0];
         timer1_count_high_nxt = step1[15:8];
         if (mode0 != tmc_pkg::MODE_SPLIT) begin
            ovf1 = step1[16]; // RULE_13
         end
      end
      // Byte writes, direct addressing only; a write beats a count step
      if (sfr_wr && direct_acc) begin // RULE_12
         unique case (sfr_addr)
            tmc_pkg::ADDR_TIMER_CONTROL: timer_control_nxt = sfr_wdata;
            tmc_pkg::ADDR_TIMER_MODE_SELECT: timer_mode_select_nxt = sfr_wdata;
            tmc_pkg::ADDR_TIMER0_COUNT_LOW: timer0_count_low_nxt = sfr_wdata;
            tmc_pkg::ADDR_TIMER1_COUNT_LOW: timer1_count_low_nxt = sfr_wdata;
            tmc_pkg::ADDR_TIMER0_COUNT_HIGH: timer0_count_high_nxt = sfr_wdata;
            tmc_pkg::ADDR_TIMER1_COUNT_HIGH: timer1_count_high_nxt = sfr_wdata;
            default: ;
         endcase
      end
      // Bit writes only reach bit-addressable locations
      if (sfr_bit_wr && direct_acc && (sfr_addr[2:0] == tmc_pkg::BIT_ADDR_LOW_BITS) &&
          (sfr_addr == tmc_pkg::ADDR_TIMER_CONTROL)) begin // RULE_11 RULE_12
         timer_control_nxt[sfr_bit_sel] = sfr_bit_val;
      end
      // Hardware set wins over a software clear in the same cycle
      if (ovf0) begin
         timer_control_nxt[tmc_pkg::CTRL_T0_OVERFLOW_BIT] = 1'b1; // RULE_13
      end
      if (ovf1) begin
         timer_control_nxt[tmc_pkg::CTRL_T1_OVERFLOW_BIT] = 1'b1; // RULE_13
      end
      // Read mux; unmapped or indirect reads return zero
      if (sfr_rd) begin
         rdata_nxt = 8'h00;
         if (direct_acc) begin // RULE_12
            unique case (sfr_addr)
               tmc_pkg::ADDR_TIMER_CONTROL: rdata_nxt = timer_control_r;
               tmc_pkg::ADDR_TIMER_MODE_SELECT: rdata_nxt = timer_mode_select_r;
               tmc_pkg::ADDR_TIMER0_COUNT_LOW: rdata_nxt = timer0_count_low_r;
               tmc_pkg::ADDR_TIMER1_COUNT_LOW: rdata_nxt = timer1_count_low_r;
               tmc_pkg::ADDR_TIMER0_COUNT_HIGH: rdata_nxt = timer0_count_high_r;
               tmc_pkg::ADDR_TIMER1_COUNT_HIGH: rdata_nxt = timer1_count_high_r;
               default: rdata_nxt = 8'h00;
            endcase
         end
      end
   end

   // Machine-cycle pulse from the divider
   assign mc_en = (mc_cnt_r == 4'(MACH_DIV - 1));

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         mc_cnt_r <= 4'h0;
         timer_control_r <= tmc_pkg::RESET_BYTE;
         timer_mode_select_r <= tmc_pkg::RESET_BYTE;
         timer0_count_low_r <= tmc_pkg::RESET_BYTE;
         timer0_count_high_r <= tmc_pkg::RESET_BYTE;
         timer1_count_low_r <= tmc_pkg::RESET_BYTE;
         timer1_count_high_r <= tmc_pkg::RESET_BYTE;
         rdata_r <= tmc_pkg::RESET_BYTE;
      end else begin
         mc_cnt_r <= mc_cnt_nxt;
         timer_control_r <= timer_control_nxt;
         timer_mode_select_r <= timer_mode_select_nxt;
         timer0_count_low_r <= timer0_count_low_nxt;
         timer0_count_high_r <= timer0_count_high_nxt;
         timer1_count_low_r <= timer1_count_low_nxt;
         timer1_count_high_r <= timer1_count_high_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // Outputs straight from flops
   assign sfr_rdata = rdata_r;
   assign timer0_overflow = timer_control_r[tmc_pkg::CTRL_T0_OVERFLOW_BIT];
   assign timer1_overflow = timer_control_r[tmc_pkg::CTRL_T1_OVERFLOW_BIT];
endmodule
`default_nettype wire

// [verification/tmc_timer_top_props.sv]
// Purpose: Port-level assertions for the dual timer/counter block.
// Assumes: Sees only the top ports; shadows mode and run bits itself.
// Notes: Bound into tmc_timer_top after the module.
`default_nettype none
module tmc_timer_props #(
   parameter int MACH_DIV = 12
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_indirect,
   input wire logic sfr_rd,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_bit_wr,
   input wire logic [2:0] sfr_bit_sel,
   input wire logic sfr_bit_val,
   input wire logic ext_irq_pin_zero,
   input wire logic ext_irq_pin_one,
   input wire logic timer0_count_pin,
   input wire logic timer1_count_pin,
   input wire logic [7:0] sfr_rdata,
   input wire logic timer0_overflow,
   input wire logic timer1_overflow
);
   // ------------------------------------------------
   // Shadow of software-written control state
   // ------------------------------------------------
   wire logic wr_ok = sfr_wr && !sfr_indirect; // Direct byte write
   wire logic ctl_bw = sfr_bit_wr && !sfr_indirect && sfr_addr == 8'h88; // Direct bit write to control
   wire logic ctl_hit = ctl_bw || (wr_ok && sfr_addr == 8'h88); // Any software write to control
   logic [7:0] mode_r, mode_nxt; // Mode register copy
   logic [1:0] run_r, run_nxt; // Run bits, timer 1 then timer 0
   // Next values; a bit write wins for its own bit
   always_comb begin
      mode_nxt = mode_r;
      run_nxt = run_r;
      if (wr_ok && sfr_addr == 8'h89) mode_nxt = sfr_wdata;
      if (wr_ok && sfr_addr == 8'h88) run_nxt = {sfr_wdata[6], sfr_wdata[4]};
      if (ctl_bw && sfr_bit_sel == 3'h6) run_nxt[1] = sfr_bit_val;
      if (ctl_bw && sfr_bit_sel == 3'h4) run_nxt[0] = sfr_bit_val;
   end
   // Register the shadows
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         mode_r <= 8'h00;
         run_r <= 2'h0;
      end else begin
         mode_r <= mode_nxt;
         run_r <= run_nxt;
      end
   end
   // ------------------------------------------------
   // Properties
   // ------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   property p_ind_rd; (sfr_rd && sfr_indirect) ##1 !sfr_rd |=> sfr_rdata == 8'h00; endproperty
   a_ind_rd: assert property (p_ind_rd) else $error("indirect read gave data");
   property p_unmap_rd; (sfr_rd && !sfr_indirect && (sfr_addr < 8'h88 || sfr_addr > 8'h8D)) ##1 !sfr_rd
      |=> sfr_rdata == 8'h00; endproperty
   a_unmap_rd: assert property (p_unmap_rd) else $error("unmapped read gave data");
   property p_t0_hold; timer0_overflow && !ctl_hit |=> timer0_overflow; endproperty
   a_t0_hold: assert property (p_t0_hold) else $error("timer 0 flag dropped by itself");
   property p_t1_hold; timer1_overflow && !ctl_hit |=> timer1_overflow; endproperty
   a_t1_hold: assert property (p_t1_hold) else $error("timer 1 flag dropped by itself");
   property p_t0_norun; !run_r[0] && !ctl_hit |=> !$rose(timer0_overflow); endproperty
   a_t0_norun: assert property (p_t0_norun) else $error("timer 0 overflowed while stopped");
   property p_t1_norun; !run_r[1] && !ctl_hit |=> !$rose(timer1_overflow); endproperty
   a_t1_norun: assert property (p_t1_norun) else $error("timer 1 overflowed while stopped");
   property p_t1_m3; mode_r[5:4] == 2'h3 && mode_r[1:0] != 2'h3 && !ctl_hit |=> !$rose(timer1_overflow); endproperty
   a_t1_m3: assert property (p_t1_m3) else $error("timer 1 counted in mode 3");
   property p_bit_set; ctl_bw && sfr_bit_sel == 3'h5 && sfr_bit_val |=> timer0_overflow; endproperty
   a_bit_set: assert property (p_bit_set) else $error("bit write missed timer 0 flag");
   c_t0_ovf: cover property ($rose(timer0_overflow));
   c_t1_ovf: cover property ($rose(timer1_overflow));
   c_ind_rd: cover property (sfr_rd && sfr_indirect);
endmodule
bind tmc_timer_top tmc_timer_props #(.MACH_DIV(MACH_DIV)) tmc_timer_props_inst (.core_clk, .reset_n, .sfr_addr,
   .sfr_indirect, .sfr_rd, .sfr_wr, .sfr_wdata, .sfr_bit_wr, .sfr_bit_sel, .sfr_bit_val, .ext_irq_pin_zero,
   .ext_irq_pin_one, .timer0_count_pin, .timer1_count_pin, .sfr_rdata, .timer0_overflow, .timer1_overflow);
`default_nettype wire

// [verification/tb_top.sv]
// Purpose: Self-checking bench for the dual timer/counter block.
// Assumes: MACH_DIV of 2 keeps internal counts short.
// Notes: Bus tasks hold each strobe for one taken edge.
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] A_CTL = tmc_pkg::ADDR_TIMER_CONTROL; // Control byte
   localparam logic [7:0] A_MODE = tmc_pkg::ADDR_TIMER_MODE_SELECT; // Mode byte
   localparam logic [7:0] L0 = tmc_pkg::ADDR_TIMER0_COUNT_LOW; // Count bytes
   localparam logic [7:0] L1 = tmc_pkg::ADDR_TIMER1_COUNT_LOW;
   localparam logic [7:0] H0 = tmc_pkg::ADDR_TIMER0_COUNT_HIGH;
   localparam logic [7:0] H1 = tmc_pkg::ADDR_TIMER1_COUNT_HIGH;
   logic core_clk = 0, reset_n = 0, sfr_indirect = 0, sfr_rd = 0, sfr_wr = 0, sfr_bit_wr = 0, sfr_bit_val = 0;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, rdv = 8'h00; // Bus fields and last read
   logic [2:0] sfr_bit_sel = 3'h0;
   logic [1:0] irq = 2'h3, cnt = 2'h3; // Pins idle high
   wire logic [7:0] sfr_rdata;
   wire logic [1:0] ovf; // Overflow flags, timer 1 then timer 0
   int n_fail = 0, checks = 0;
   tmc_timer_top #(.MACH_DIV(2)) tmc_timer_top_inst (.core_clk, .reset_n, .sfr_addr, .sfr_indirect, .sfr_rd,
      .sfr_wr, .sfr_wdata, .sfr_bit_wr, .sfr_bit_sel, .sfr_bit_val, .ext_irq_pin_zero(irq[0]),
      .ext_irq_pin_one(irq[1]), .timer0_count_pin(cnt[0]), .timer1_count_pin(cnt[1]), .sfr_rdata,
      .timer0_overflow(ovf[0]), .timer1_overflow(ovf[1]));
   // ------------------------------------------------
   // Shared tasks
   // ------------------------------------------------
   task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Op 0 read, 1 byte write, 2 bit write (d[7] value, d[2:0] bit)
   task bus(input int op, input logic [7:0] a, input logic [7:0] d, input logic ind);
      @(posedge core_clk);
      #1;
      sfr_addr = a;
      sfr_wdata = d;
      sfr_bit_sel = d[2:0];
      sfr_bit_val = d[7];
      sfr_indirect = ind;
      sfr_rd = (op == 0);
      sfr_wr = (op == 1);
      sfr_bit_wr = (op == 2);
      @(posedge core_clk);
      #1;
      sfr_rd = 0;
      sfr_wr = 0;
      sfr_bit_wr = 0;
      @(posedge core_clk);
      #1;
      rdv = sfr_rdata;
   endtask
   task rd_chk(input logic [7:0] a, input logic [7:0] exp);
      bus(0, a, 8'h00, 0);
      chk("read", rdv, exp);
   endtask
   // Stop and clear, then load mode, bytes and control
   task setup(input logic [7:0] m, la, l, ha, h, c);
      bus(1, A_CTL, 8'h00, 0);
      bus(1, A_MODE, m, 0);
      bus(1, la, l, 0);
      bus(1, ha, h, 0);
      bus(1, A_CTL, c, 0);
   endtask
   // Wait up to n cycles for a flag, then compare with exp
   task wait_ovf(input int idx, input int n, input logic exp);
      int i;
      i = 0;
      while (i < n && ovf[idx] !== 1'b1) begin
         @(posedge core_clk);
         #1;
         i++;
      end
      chk("overflow", {7'h00, ovf[idx]}, {7'h00, exp});
   endtask
   task fall(input int idx);
      cnt[idx] = 0;
      repeat (4) @(posedge core_clk);
      #1;
      cnt[idx] = 1;
      repeat (4) @(posedge core_clk);
      #1;
   endtask
   // ------------------------------------------------
   // Scenarios
   // ------------------------------------------------
   task t_regs;
      for (int a = 8'h88; a <= 8'h8E; a++) rd_chk(a[7:0], 8'h00);
      for (int a = 8'h89; a <= 8'h8E; a++) begin
         bus(1, a[7:0], a[7:0] ^ 8'h5A, 0);
         rd_chk(a[7:0], (a == 8'h8E) ? 8'h00 : a[7:0] ^ 8'h5A);
      end
      bus(1, A_MODE, 8'h00, 1);
      rd_chk(A_MODE, 8'hD3);
      bus(0, A_MODE, 8'h00, 1);
      chk("indirect read", rdv, 8'h00);
   endtask
   task t_bits;
      bus(2, A_CTL, 8'h83, 0);
      rd_chk(A_CTL, 8'h08);
      bus(2, A_CTL, 8'h85, 0);
      rd_chk(A_CTL, 8'h28);
      bus(2, A_MODE, 8'h82, 0);
      rd_chk(A_MODE, 8'hD3);
      bus(2, A_CTL, 8'h86, 1);
      bus(2, A_CTL, 8'h05, 0);
      rd_chk(A_CTL, 8'h08);
   endtask
   task t_modes;
      setup(8'h01, L0, 8'hFE, H0, 8'hFF, 8'h10);
      wait_ovf(0, 40, 1);
      bus(1, A_CTL, 8'h00, 0);
      rd_chk(H0, 8'h00);
      setup(8'h00, L0, 8'hFF, H0, 8'hFF, 8'h10);
      wait_ovf(0, 40, 1);
      bus(1, A_CTL, 8'h00, 0);
      bus(0, L0, 8'h00, 0);
      chk("prescale top", rdv & 8'hE0, 8'hE0);
      setup(8'h02, L0, 8'hFE, H0, 8'hF0, 8'h10);
      wait_ovf(0, 40, 1);
      bus(1, A_CTL, 8'h00, 0);
      bus(0, L0, 8'h00, 0);
      chk("reloaded low", rdv & 8'hF0, 8'hF0);
      rd_chk(H0, 8'hF0);
      setup(8'h20, L1, 8'hFE, H1, 8'hF0, 8'h40);
      wait_ovf(1, 40, 1);
      rd_chk(H1, 8'hF0);
   endtask
   task t_gate(input int idx);
      irq[idx] = 0;
      setup(idx ? 8'h90 : 8'h09, idx ? L1 : L0, 8'hFF, idx ? H1 : H0, 8'hFF, idx ? 8'h40 : 8'h10);
      wait_ovf(idx, 40, 0);
      irq[idx] = 1;
      wait_ovf(idx, 40, 1);
      irq[idx] = 0;
      setup(idx ? 8'h10 : 8'h01, idx ? L1 : L0, 8'hFF, idx ? H1 : H0, 8'hFF, idx ? 8'h40 : 8'h10);
      wait_ovf(idx, 40, 1);
      irq[idx] = 1;
   endtask
   task t_src(input int idx);
      setup(idx ? 8'h50 : 8'h05, idx ? L1 : L0, 8'hFE, idx ? H1 : H0, 8'hFF, idx ? 8'h40 : 8'h10);
      wait_ovf(idx, 40, 0);
      fall(idx);
      fall(idx);
      wait_ovf(idx, 20, 1);
   endtask
   task t_split;
      setup(8'h03, H0, 8'hFF, L0, 8'h00, 8'h40);
      wait_ovf(1, 40, 1);
      chk("timer 0 flag", {7'h00, ovf[0]}, 8'h00);
      // Split low byte runs on timer 0's own run bit
      bus(1, L0, 8'hFF, 0);
      bus(2, A_CTL, 8'h84, 0);
      wait_ovf(0, 40, 1);
      // Timer 1 still rolls over in split mode but leaves its flag alone
      setup(8'h13, L1, 8'hFF, H1, 8'hFF, 8'h40);
      wait_ovf(1, 20, 0);
      rd_chk(H1, 8'h00);
      setup(8'h30, L1, 8'hFF, H1, 8'hFF, 8'h40);
      wait_ovf(1, 40, 0);
      rd_chk(L1, 8'hFF);
   endtask
   // Reset in mid-run clears registers and flags
   task t_reset;
      reset_n = 0;
      repeat (2) @(posedge core_clk);
      #1;
      reset_n = 1;
      chk("flags after reset", {6'h00, ovf}, 8'h00);
      rd_chk(A_MODE, 8'h00);
      rd_chk(L1, 8'h00);
   endtask
   task end_of_test;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Clock, watchdog and main sequence
   initial begin
      forever #2.5 core_clk = ~core_clk;
   end
   initial begin
      #200000;
      n_fail++;
      end_of_test();
   end
   initial begin
      repeat (8) @(posedge core_clk);
      #1;
      reset_n = 1;
      t_regs();
      t_bits();
      t_modes();
      t_gate(0);
      t_gate(1);
      t_src(0);
      t_src(1);
      t_split();
      t_reset();
      end_of_test();
   end
endmodule
`default_nettype wire
